//--- src/ctr_pkg.sv
// Package for the pulse generator and time measurement counter.
// Assumes a single 125 MHz clock domain; counter width fixed here.
package ctr_pkg;

  localparam int CNT_W = 32;

  // Reset value and count step
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

  // Edge polarity codes
  localparam logic POL_RISE = 1'b0;
  localparam logic POL_FALL = 1'b1;

  typedef enum logic [1:0] {
    GEN_SINGLE,
    GEN_FINITE,
    GEN_CONT
  } gen_mode_t;

  typedef enum logic [1:0] {
    MEAS_PERIOD,
    MEAS_SEMI,
    MEAS_WIDTH,
    MEAS_TWOEDGE
  } meas_mode_t;

  // Pulse specification, in timebase ticks
  typedef struct packed {
    logic             idleHigh;
    gen_mode_t        mode;
    logic [CNT_W-1:0] highTicks;
    logic [CNT_W-1:0] lowTicks;
    logic [CNT_W-1:0] initDelay;
    logic [CNT_W-1:0] pulseCount;
  } gen_cfg_t;

  typedef struct packed {
    meas_mode_t mode;
    logic       startPol;
    logic       endPol;
  } meas_cfg_t;

  typedef struct packed {
    logic [CNT_W-1:0] ticks;
    logic             valid;
  } meas_res_t;

endpackage

//--- src/pulse_gen_time_measure_counter.sv
// Counter block: pulse generation on the output terminal and time
// measurement in timebase ticks. Inputs from pins are synchronised here.
//
// Summary of operation
// - Output idles low or high; pulses move away and return to idle.
// - Each pulse is a programmed high duration and low duration.
// - Output holds idle level for the initial delay before first pulse.
// - Initial delay replaces the first pulse phase that matches idle.
// - Period equals high plus low duration; frequency is its reciprocal.
// - Timing as frequency/duty, times or raw ticks; hardware takes ticks.
// - Generated waveform drives the dedicated counter output terminal.
// - Modes: single pulse, finite train of N pulses, continuous train.
// - Period mode measures between consecutive same-polarity edges.
// - Semi-period mode measures between every pair of consecutive edges.
// - Pulse-width mode measures from one edge to next opposite edge.
// - Two-edge mode measures edge on input A to edge on input B.
// - Every result is a count of timebase ticks over the interval.
// - Timebase is the internal clock or an external tick input.
`timescale 1ns/1ps

module pulse_gen_time_measure_counter
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Timebase
  input  wire logic             extTbSel,
  input  wire logic             extTbPin,
  // Generator control
  input  wire ctr_pkg::gen_cfg_t genCfg,
  input  wire logic             genStart,
  input  wire logic             genStop,
  output logic                  ctrOut,
  output logic                  genBusy,
  output logic                  genDone,
  input  wire logic             genDoneClr,
  // Measurement control
  input  wire ctr_pkg::meas_cfg_t measCfg,
  input  wire logic             measEnable,
  input  wire logic             measPinA,
  input  wire logic             measPinB,
  output ctr_pkg::meas_res_t    measRes,
  input  wire logic             measAck
);
  import ctr_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] tbSync_q, aSync_q, bSync_q;
  logic [2:0] tbSync_d, aSync_d, bSync_d;
  logic       tbLvl_q, aLvl_q, bLvl_q;
  logic       tbLvl_d, aLvl_d, bLvl_d;

  function automatic logic agreed(input logic [2:0] s, input logic old);
    return (s[1] == s[2]) ? s[2] : old;
  endfunction

  always_comb begin
    tbSync_d = {tbSync_q[1:0], extTbPin};
    aSync_d  = {aSync_q[1:0], measPinA};
    bSync_d  = {bSync_q[1:0], measPinB};
    tbLvl_d  = agreed(tbSync_q, tbLvl_q);
    aLvl_d   = agreed(aSync_q, aLvl_q);
    bLvl_d   = agreed(bSync_q, bLvl_q);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tbSync_q <= 3'h0;
      aSync_q  <= 3'h0;
      bSync_q  <= 3'h0;
      tbLvl_q  <= 1'b0;
      aLvl_q   <= 1'b0;
      bLvl_q   <= 1'b0;
    end else begin
      tbSync_q <= tbSync_d;
      aSync_q  <= aSync_d;
      bSync_q  <= bSync_d;
      tbLvl_q  <= tbLvl_d;
      aLvl_q   <= aLvl_d;
      bLvl_q   <= bLvl_d;
    end
  end

  logic tick, aRise, aFall, bRise, bFall;
  assign tick  = extTbSel ? (tbLvl_d & ~tbLvl_q) : 1'b1;
  assign aRise = aLvl_d & ~aLvl_q;
  assign aFall = ~aLvl_d & aLvl_q;
  assign bRise = bLvl_d & ~bLvl_q;
  assign bFall = ~bLvl_d & bLvl_q;

  // ----------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {G_IDLE, G_DELAY, G_ACTIVE, G_REST} gstate_t;
  gstate_t          gState_q, gState_d;
  logic [CNT_W-1:0] gCnt_q, gCnt_d, gLeft_q, gLeft_d;
  logic             out_q, out_d, done_q, done_d;
  logic             gCntEnd;

  // Active phase is opposite to idle; rest phase equals idle
  function automatic logic [CNT_W-1:0] phaseLen(input gen_cfg_t c,
                                                 input logic active);
    return (active ^ c.idleHigh) ? c.highTicks : c.lowTicks;
  endfunction

  assign gCntEnd = tick && (gCnt_q <= CNT_ONE);

  always_comb begin
    gState_d = gState_q;
    gCnt_d   = gCnt_q;
    gLeft_d  = gLeft_q;
    out_d    = out_q;
    done_d   = done_q & ~genDoneClr;
    if (tick && gCnt_q != CNT_ZERO)
      gCnt_d = gCnt_q - CNT_ONE;
    case (gState_q)
      G_IDLE: begin
        out_d = genCfg.idleHigh;
        if (genStart) begin
          gState_d = G_DELAY;
          gCnt_d   = genCfg.initDelay;
          gLeft_d  = (genCfg.mode == GEN_FINITE) ? genCfg.pulseCount
                                                  : CNT_ONE;
        end
      end
      G_DELAY: begin
        // Delay stands in for the first idle-level phase
        if (gCntEnd) begin
          gState_d = G_ACTIVE;
          out_d    = ~genCfg.idleHigh;
          gCnt_d   = phaseLen(genCfg, 1'b1);
        end
      end
      G_ACTIVE: begin
        if (gCntEnd) begin
          out_d = genCfg.idleHigh;
          if (genCfg.mode != GEN_CONT && gLeft_q <= CNT_ONE) begin
            gState_d = G_IDLE;
            done_d   = 1'b1;
            gLeft_d  = CNT_ZERO;
          end else begin
            gState_d = G_REST;
            gCnt_d   = phaseLen(genCfg, 1'b0);
            gLeft_d  = gLeft_q - CNT_ONE;
          end
        end
      end
      G_REST: begin
        if (gCntEnd) begin
          gState_d = G_ACTIVE;
          out_d    = ~genCfg.idleHigh;
          gCnt_d   = phaseLen(genCfg, 1'b1);
        end
      end
      default: gState_d = G_IDLE;
    endcase
    if (genStop && gState_q != G_IDLE) begin
      gState_d = G_IDLE;
      out_d    = genCfg.idleHigh;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      gState_q <= G_IDLE;
      gCnt_q   <= CNT_ZERO;
      gLeft_q  <= CNT_ZERO;
      out_q    <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      gState_q <= gState_d;
      gCnt_q   <= gCnt_d;
      gLeft_q  <= gLeft_d;
      out_q    <= out_d;
      done_q   <= done_d;
    end
  end

  assign ctrOut  = out_q;
  assign genBusy = (gState_q != G_IDLE);
  assign genDone = done_q;

  // ----------------------------------------------------------------
  // Time measurement
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] mCnt_q, mCnt_d, res_q, res_d;
  logic             run_q, run_d, valid_q, valid_d;
  logic             startEv, endEv;

  function automatic logic edgeOf(input logic pol, input logic r,
                                  input logic f);
    return (pol == POL_FALL) ? f : r;
  endfunction

  always_comb begin
    case (measCfg.mode)
      MEAS_PERIOD: begin
        startEv = edgeOf(measCfg.startPol, aRise, aFall);
        endEv   = startEv;
      end
      MEAS_SEMI: begin
        startEv = aRise | aFall;
        endEv   = startEv;
      end
      MEAS_WIDTH: begin
        startEv = edgeOf(measCfg.startPol, aRise, aFall);
        endEv   = edgeOf(~measCfg.startPol, aRise, aFall);
      end
      MEAS_TWOEDGE: begin
        startEv = edgeOf(measCfg.startPol, aRise, aFall);
        endEv   = edgeOf(measCfg.endPol, bRise, bFall);
      end
      default: begin
        startEv = 1'b0;
        endEv   = 1'b0;
      end
    endcase
  end

  always_comb begin
    mCnt_d  = mCnt_q;
    run_d   = run_q;
    res_d   = res_q;
    valid_d = valid_q & ~measAck;
    if (!measEnable) begin
      run_d = 1'b0;
    end else begin
      if (run_q && tick)
        mCnt_d = mCnt_q + CNT_ONE;
      if (run_q && endEv) begin
        res_d   = mCnt_d;
        valid_d = 1'b1;
        run_d   = 1'b0;
      end
      if (startEv) begin
        mCnt_d = CNT_ZERO;
        run_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mCnt_q  <= CNT_ZERO;
      res_q   <= CNT_ZERO;
      run_q   <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      mCnt_q  <= mCnt_d;
      res_q   <= res_d;
      run_q   <= run_d;
      valid_q <= valid_d;
    end
  end

  assign measRes = '{ticks: res_q, valid: valid_q};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_finalEdge;
    gState_q == G_ACTIVE && gCntEnd && !genStop
      && genCfg.mode != GEN_CONT && gLeft_q <= CNT_ONE;
  endsequence

  chk_idle_level: assert property (@(posedge clk) disable iff (!nrst)
    gState_q == G_IDLE && $past(nrst) |-> ctrOut == $past(genCfg.idleHigh)
  ) else $error("idle output level wrong");

  chk_active_level: assert property (@(posedge clk)
    disable iff (!nrst)
    gState_q == G_ACTIVE |-> ctrOut != genCfg.idleHigh
  ) else $error("active phase level wrong");

  chk_delay_idle: assert property (@(posedge clk) disable iff (!nrst)
    gState_q == G_DELAY |-> ctrOut == genCfg.idleHigh
  ) else $error("output left idle during delay");

  chk_finite_done: assert property (@(posedge clk) disable iff (!nrst)
    s_finalEdge |=> genDone && !genBusy && ctrOut == genCfg.idleHigh
  ) else $error("finite train did not finish");

  chk_stop_idle: assert property (@(posedge clk) disable iff (!nrst)
    genStop && genBusy |=> !genBusy
  ) else $error("stop not honoured");

  chk_start_clear: assert property (@(posedge clk) disable iff (!nrst)
    measEnable && startEv |=> run_q && mCnt_q == CNT_ZERO
  ) else $error("counter not cleared at start");

  chk_result_latch: assert property (@(posedge clk)
    disable iff (!nrst)
    measEnable && run_q && endEv && !startEv && tick
      |=> measRes.valid && measRes.ticks == $past(mCnt_q) + CNT_ONE
  ) else $error("result not latched");

  chk_int_tick: assert property (@(posedge clk) disable iff (!nrst)
    run_q && !extTbSel && measEnable && !startEv
      |=> mCnt_q == $past(mCnt_q) + CNT_ONE
  ) else $error("tick count not advancing");

endmodule // pulse_gen_time_measure_counter

//--- verif/ext_sig_model.sv
// Model of the external signals: measured pins and external timebase.
// Assumes the bench calls drv from its own processes, after a clk edge.
`timescale 1ns/1ps

module ext_sig_model (
  // Clock
  input  wire logic clk,
  // Pins toward the counter
  output logic      pinA,
  output logic      pinB,
  output logic      tbPin
);
  logic       tbRun = 1'b0;
  logic [1:0] div   = 2'h0;

  initial begin
    pinA = 1'b0;
    pinB = 1'b0;
  end

  // ---------------------------------------------------------------
  // External tick source, one rise per 4 clk, quiet when stopped
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    div   <= div + 2'h1;
    tbPin <= tbRun & div[1];
  end

  // Move both pins n clk edges from now
  task automatic drv(input int n, input logic a, input logic b);
    repeat (n) @(posedge clk);
    #1;
    pinA = a;
    pinB = b;
  endtask
endmodule // ext_sig_model

//--- verif/test_pulse_gen_time_measure_counter.sv
// Self-checking bench for the counter: generator and measurement.
// Assumes ctr_pkg and ext_sig_model are compiled before this file.
`timescale 1ns/1ps

module test_pulse_gen_time_measure_counter;
  import ctr_pkg::*;
  logic      clk, nrst, extTbSel, genStart, genStop, genDoneClr;
  logic      measEnable, measAck, ctrOut, genBusy, genDone;
  logic      pinA, pinB, tbPin;
  gen_cfg_t  genCfg;
  meas_cfg_t measCfg;
  meas_res_t measRes;
  int        error_cnt, cmp_count;

  pulse_gen_time_measure_counter dut_u (.clk(clk), .nrst(nrst),
    .extTbSel(extTbSel), .extTbPin(tbPin), .genCfg(genCfg),
    .genStart(genStart), .genStop(genStop), .ctrOut(ctrOut),
    .genBusy(genBusy), .genDone(genDone), .genDoneClr(genDoneClr),
    .measCfg(measCfg), .measEnable(measEnable), .measPinA(pinA),
    .measPinB(pinB), .measRes(measRes), .measAck(measAck));
  ext_sig_model m (.clk(clk), .pinA(pinA), .pinB(pinB), .tbPin(tbPin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic timeout(input int w);
    if (w >= 300) begin
      error_cnt++;
      $display("MISMATCH %0t wait ran out", $time);
      report_and_stop();
    end
  endtask

  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask

  // Cycles until ctrOut shows lvl, then length of that run
  task automatic runlen(input logic lvl, output int w, output int n);
    n = 0;
    for (w = 0; w < 300 && ctrOut !== lvl; w++) @(negedge clk);
    timeout(w);
    while (ctrOut === lvl && n < 300) begin
      n++;
      @(negedge clk);
    end
  endtask

  task automatic meas_wait(output logic [31:0] t);
    int w;
    for (w = 0; w < 300 && measRes.valid !== 1'b1; w++) @(negedge clk);
    timeout(w);
    t = measRes.ticks;
    pulse(measAck);
  endtask

  // Pin steps {A,B} at 2, d2, d3 clk apart; nres results expected
  task automatic meas_run(meas_mode_t md, logic sp, ep, logic [5:0] p,
                          int d2, d3, logic [31:0] e1, e2, int nres);
    logic [31:0] t;
    m.drv(1, 1'b0, 1'b0);
    measEnable = 1'b0;
    m.drv(4, 1'b0, 1'b0);
    measCfg = '{md, sp, ep};
    measEnable = 1'b1;
    fork
      begin
        m.drv(2, p[5], p[4]);
        m.drv(d2, p[3], p[2]);
        m.drv(d3, p[1], p[0]);
      end
      for (int r = 0; r < nres; r++) begin
        meas_wait(t);
        chk(t, r ? e2 : e1, "measured ticks");
      end
    join
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_single();
    int w, n;
    genCfg = '{1'b0, GEN_SINGLE, 32'h2, 32'h3, 32'h2, 32'h1};
    pulse(genStart);
    @(negedge clk);
    chk(genBusy, 1'b1, "busy");
    runlen(1'b1, w, n);
    chk(w, 32'h2, "initial delay");
    chk(n, 32'h2, "high time");
    chk({genDone, genBusy}, 2'h2, "single done");
    pulse(genDoneClr);
    @(negedge clk);
    chk(genDone, 1'b0, "done cleared");
  endtask

  task automatic t_finite();
    int w, n;
    @(posedge clk);
    #1 genCfg = '{1'b1, GEN_FINITE, 32'h2, 32'h3, 32'h4, 32'h3};
    // Output follows the new idle level one edge later
    repeat (2) @(negedge clk);
    chk(ctrOut, 1'b1, "idle high");
    pulse(genStart);
    pulse(genStart);
    // Two of the four delay ticks pass during the refused start
    for (int i = 0; i < 3; i++) begin
      runlen(1'b0, w, n);
      chk(n, 32'h3, "low time");
      if (i > 0) chk(w, 32'h2, "rest time");
      else chk(w, 32'h3, "delay in place of rest");
    end
    repeat (6) @(negedge clk);
    chk({ctrOut, genDone, genBusy}, 3'h6, "train end");
    pulse(genDoneClr);
  endtask

  task automatic t_cont();
    int w, n;
    genCfg = '{1'b0, GEN_CONT, 32'h1, 32'h1, 32'h1, 32'h0};
    pulse(genStart);
    for (int i = 0; i < 5; i++) begin
      runlen(1'b1, w, n);
      chk(n, 32'h1, "cont high");
      if (i > 0) chk(w, 32'h1, "cont low");
    end
    pulse(genStop);
    @(negedge clk);
    chk({ctrOut, genBusy, genDone}, 3'h0, "stopped");
  endtask

  initial begin
    nrst = 1'b0;
    extTbSel = 1'b0;
    genStart = 1'b0;
    genStop = 1'b0;
    genDoneClr = 1'b0;
    measEnable = 1'b0;
    measAck = 1'b0;
    genCfg = '{1'b0, GEN_SINGLE, 32'h1, 32'h1, 32'h1, 32'h1};
    measCfg = '{MEAS_PERIOD, POL_RISE, POL_RISE};
    error_cnt = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    t_single();
    t_finite();
    t_cont();
    meas_run(MEAS_PERIOD, POL_RISE, POL_RISE, 6'h22, 5, 5, 10, 0, 1);
    meas_run(MEAS_SEMI, POL_RISE, POL_RISE, 6'h22, 4, 10, 4, 10, 2);
    meas_run(MEAS_WIDTH, POL_RISE, POL_FALL, 6'h20, 5, 3, 5, 0, 1);
    meas_run(MEAS_WIDTH, POL_FALL, POL_RISE, 6'h22, 3, 6, 6, 0, 1);
    meas_run(MEAS_TWOEDGE, POL_RISE, POL_RISE, 6'h2f, 7, 1, 7, 0, 1);
    extTbSel = 1'b1;
    m.tbRun = 1'b1;
    meas_run(MEAS_PERIOD, POL_RISE, POL_RISE, 6'h22, 20, 20, 10, 0, 1);
    report_and_stop();
  end
endmodule // test_pulse_gen_time_measure_counter
